// ---- mask_bank_consts.vh ----
`ifndef MASK_BANK_CONSTS_VH
`define MASK_BANK_CONSTS_VH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define OFS_UPPER_PIN_TRIG 8'h48
`define OFS_RAIL_PAIR_A 8'h49
`define OFS_RAIL_PAIR_B 8'h4a
// ------------------------------------------------------------
// Field positions, rail pair registers (per nibble)
// ------------------------------------------------------------
`define POS_OV 0
`define POS_UV 1
`define POS_RSVD_NIB 2
`define POS_ILIM 3
`define POS_HI_NIBBLE 4
// ------------------------------------------------------------
// Field positions, upper pin trigger register
// ------------------------------------------------------------
`define POS_P9_BLOCK 0
`define POS_P9_LEVEL 1
`define POS_P10_BLOCK 2
`define POS_P10_LEVEL 3
// ------------------------------------------------------------
// Reset values, before the non-volatile load
// ------------------------------------------------------------
`define RST_RAIL_PAIR 8'h00
`define RST_UPPER_PIN 8'h00
`endif

// ---- mask_bank_props.sv ----
`timescale 1ns/1ps
module mask_bank_props (
   input wire clk,
   input wire rst_n,
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   input wire nvm_load,
   input wire [7:0] nvm_upper_pin,
   input wire [3:0] rail_current_event,
   input wire [3:0] rail_undervolt_event,
   input wire [3:0] rail_overvolt_event,
   input wire [3:0] rail_current_irq,
   input wire [3:0] rail_undervolt_irq,
   input wire [3:0] rail_overvolt_irq,
   input wire pin_nine_trigger_in,
   input wire pin_ten_trigger_in,
   input wire pin_nine_trigger_out,
   input wire pin_ten_trigger_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Write steps; a load in the same cycle wins, so it is excluded
   sequence wr_a; reg_wr && !nvm_load && reg_addr == 8'h49; endsequence
   sequence wr_p; reg_wr && !nvm_load && reg_addr == 8'h48; endsequence
   chk_rail_readback: assert property (wr_a ##1 reg_addr == 8'h49
      |-> reg_rdata == $past(reg_wdata)) else $error("readback wrong");
   chk_ilim_gate: assert property (wr_a |=> rail_current_irq[1:0] ==
      (rail_current_event[1:0] & ~{$past(reg_wdata[7]), $past(reg_wdata[3])}))
      else $error("ilim gate wrong");
   chk_uv_gate: assert property (wr_a |=> rail_undervolt_irq[1:0] ==
      (rail_undervolt_event[1:0] & ~{$past(reg_wdata[5]), $past(reg_wdata[1])}))
      else $error("uv gate wrong");
   chk_ov_gate: assert property (wr_a |=> rail_overvolt_irq[1:0] ==
      (rail_overvolt_event[1:0] & ~{$past(reg_wdata[4]), $past(reg_wdata[0])}))
      else $error("ov gate wrong");
   chk_pin_nine: assert property (wr_p |=> pin_nine_trigger_out ==
      ($past(reg_wdata[0]) ? $past(reg_wdata[1]) : pin_nine_trigger_in))
      else $error("pin nine wrong");
   chk_pin_ten: assert property (wr_p |=> pin_ten_trigger_out ==
      ($past(reg_wdata[2]) ? $past(reg_wdata[3]) : pin_ten_trigger_in))
      else $error("pin ten wrong");
   chk_nvm_default: assert property (nvm_load ##1 reg_addr == 8'h48
      |-> reg_rdata == $past(nvm_upper_pin)) else $error("load wrong");
   chk_rsvd_store: assert property (wr_p ##1 reg_addr == 8'h48
      |-> reg_rdata[7:4] == $past(reg_wdata[7:4])) else $error("rsvd wrong");
endmodule // mask_bank_props
bind regulator_fault_irq_mask_bank mask_bank_props chk_i (.*);

// ---- pin_trigger_gate.v ----
`timescale 1ns/1ps
// Masks one pin trigger and forces a chosen level while masked
module pin_trigger_gate (
   trigger_in,
   block,
   forced_level,
   trigger_out
);
   input wire trigger_in;
   input wire block;
   input wire forced_level;
   output wire trigger_out;

   // ---------------------------------------------------------
   // Gate
   // ---------------------------------------------------------
   // Pass when clear, forced level when blocked
   assign trigger_out = block ? forced_level : trigger_in; // (R01) (R02)
endmodule // pin_trigger_gate

// ---- regulator_fault_irq_mask_bank.v ----
`timescale 1ns/1ps
`include "mask_bank_consts.vh"
// Overview of operation
// (R01) Pin nine/ten trigger passes when block bit 0, blocked when 1.
// (R02) Blocked trigger shows its forced level bit: 0 gives 0, 1 gives 1.
// (R03) All mask and level bits load their start value from non-volatile memory.
// (R04) Current-limit mask bit 0 lets interrupt through, 1 suppresses it.
// (R05) Under-voltage mask bit 0 lets interrupt through, 1 suppresses it.
// (R06) Over-voltage mask bit 0 lets interrupt through, 1 suppresses it.
// (R07) Higher rail in bits 7:4, lower in 3:0; ilim, rsvd, uv, ov.
// (R08) Reserved bits are plain storage, read zero until written; an NVM load also sets them.
module regulator_fault_irq_mask_bank (
   input wire clk,
   input wire rst_n,
   // Register port of the serial control interface
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire [7:0] reg_wdata,
   output wire [7:0] reg_rdata,
   output wire reg_hit,
   // Non-volatile defaults, one load pulse
   input wire nvm_load,
   input wire [7:0] nvm_rail_pair_a,
   input wire [7:0] nvm_rail_pair_b,
   input wire [7:0] nvm_upper_pin,
   // Raw monitor events, rails one to four
   input wire [3:0] rail_current_event,
   input wire [3:0] rail_undervolt_event,
   input wire [3:0] rail_overvolt_event,
   // Gated events to the interrupt status logic
   output wire [3:0] rail_current_irq,
   output wire [3:0] rail_undervolt_irq,
   output wire [3:0] rail_overvolt_irq,
   // Pin nine and ten state-machine triggers
   input wire pin_nine_trigger_in,
   input wire pin_ten_trigger_in,
   output wire pin_nine_trigger_out,
   output wire pin_ten_trigger_out
);

   // ---------------------------------------------------------
   // Storage
   // ---------------------------------------------------------
   reg [7:0] rail_pair_a_fault_irq_mask_q;
   reg [7:0] rail_pair_b_fault_irq_mask_q;
   reg [7:0] upper_pin_trigger_mask_q;
   reg [7:0] rail_pair_a_fault_irq_mask_d;
   reg [7:0] rail_pair_b_fault_irq_mask_d;
   reg [7:0] upper_pin_trigger_mask_d;
   reg [7:0] rdata_d;
   wire [7:0] pin_mask_w;

   // Register selects, shared by write, read and hit logic
   wire sel_rail_pair_a;
   wire sel_rail_pair_b;
   wire sel_upper_pin;

   // Named mask fields of rail pair A, rails one and two
   wire rail_one_current_irq_block;
   wire rail_one_undervolt_irq_block;
   wire rail_one_overvolt_irq_block;
   wire rail_two_current_irq_block;
   wire rail_two_undervolt_irq_block;
   wire rail_two_overvolt_irq_block;

   // Named mask fields of rail pair B, rails three and four
   wire rail_three_current_irq_block;
   wire rail_three_undervolt_irq_block;
   wire rail_three_overvolt_irq_block;
   wire rail_four_current_irq_block;
   wire rail_four_undervolt_irq_block;
   wire rail_four_overvolt_irq_block;

   // Named pin trigger fields
   wire pin_nine_trigger_block;
   wire pin_nine_trigger_forced_level;
   wire pin_ten_trigger_block;
   wire pin_ten_trigger_forced_level;

   // Nibble field extract, used for every rail
   function get_bit;
      input [7:0] reg_value;
      input hi;
      input [1:0] pos;
      begin
         get_bit = reg_value[{hi, pos}];
      end
   endfunction

   // ---------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------
   // Full compare on purpose: aliases would let stray writes land
   assign sel_rail_pair_a = (reg_addr == `OFS_RAIL_PAIR_A);
   assign sel_rail_pair_b = (reg_addr == `OFS_RAIL_PAIR_B);
   assign sel_upper_pin = (reg_addr == `OFS_UPPER_PIN_TRIG);

   // ---------------------------------------------------------
   // Next register values
   // ---------------------------------------------------------
   // NVM load wins over a software write in the same cycle, so
   // the device always comes up with the programmed defaults.
   always @* begin
      rail_pair_a_fault_irq_mask_d = rail_pair_a_fault_irq_mask_q;
      rail_pair_b_fault_irq_mask_d = rail_pair_b_fault_irq_mask_q;
      upper_pin_trigger_mask_d = upper_pin_trigger_mask_q;
      if (nvm_load) begin
         rail_pair_a_fault_irq_mask_d = nvm_rail_pair_a; // (R03)
         rail_pair_b_fault_irq_mask_d = nvm_rail_pair_b; // (R03)
         upper_pin_trigger_mask_d = nvm_upper_pin; // (R03)
      end else if (reg_wr) begin
         // Reserved bits kept as plain storage, no write mask
         if (sel_rail_pair_a) begin
            rail_pair_a_fault_irq_mask_d = reg_wdata; // (R08)
         end
         if (sel_rail_pair_b) begin
            rail_pair_b_fault_irq_mask_d = reg_wdata; // (R08)
         end
         if (sel_upper_pin) begin
            upper_pin_trigger_mask_d = reg_wdata; // (R08)
         end
      end
   end

   // ---------------------------------------------------------
   // Register flops
   // ---------------------------------------------------------
   // Reserved bits clear at reset so they read zero until written or loaded from NVM
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rail_pair_a_fault_irq_mask_q <= `RST_RAIL_PAIR; // (R08)
         rail_pair_b_fault_irq_mask_q <= `RST_RAIL_PAIR;
         upper_pin_trigger_mask_q <= `RST_UPPER_PIN;
      end else begin
         rail_pair_a_fault_irq_mask_q <= rail_pair_a_fault_irq_mask_d;
         rail_pair_b_fault_irq_mask_q <= rail_pair_b_fault_irq_mask_d;
         upper_pin_trigger_mask_q <= upper_pin_trigger_mask_d;
      end
   end

   // ---------------------------------------------------------
   // Read-back
   // ---------------------------------------------------------
   // Unmapped addresses read zero and drop reg_hit
   always @* begin
      rdata_d = 8'h00;
      if (sel_rail_pair_a) begin
         rdata_d = rail_pair_a_fault_irq_mask_q;
      end
      if (sel_rail_pair_b) begin
         rdata_d = rail_pair_b_fault_irq_mask_q;
      end
      if (sel_upper_pin) begin
         rdata_d = upper_pin_trigger_mask_q;
      end
   end
   assign reg_rdata = rdata_d;
   assign reg_hit = sel_rail_pair_a | sel_rail_pair_b | sel_upper_pin;

   // ---------------------------------------------------------
   // Field view
   // ---------------------------------------------------------
   // Rails one/three in the low nibble, two/four in the high one
   assign rail_one_current_irq_block =
      get_bit(rail_pair_a_fault_irq_mask_q, 1'b0, 2'd`POS_ILIM); // (R07)
   assign rail_one_undervolt_irq_block =
      get_bit(rail_pair_a_fault_irq_mask_q, 1'b0, 2'd`POS_UV); // (R07)
   assign rail_one_overvolt_irq_block =
      get_bit(rail_pair_a_fault_irq_mask_q, 1'b0, 2'd`POS_OV); // (R07)
   assign rail_two_current_irq_block =
      get_bit(rail_pair_a_fault_irq_mask_q, 1'b1, 2'd`POS_ILIM); // (R07)
   assign rail_two_undervolt_irq_block =
      get_bit(rail_pair_a_fault_irq_mask_q, 1'b1, 2'd`POS_UV); // (R07)
   assign rail_two_overvolt_irq_block =
      get_bit(rail_pair_a_fault_irq_mask_q, 1'b1, 2'd`POS_OV); // (R07)
   assign rail_three_current_irq_block =
      get_bit(rail_pair_b_fault_irq_mask_q, 1'b0, 2'd`POS_ILIM); // (R07)
   assign rail_three_undervolt_irq_block =
      get_bit(rail_pair_b_fault_irq_mask_q, 1'b0, 2'd`POS_UV); // (R07)
   assign rail_three_overvolt_irq_block =
      get_bit(rail_pair_b_fault_irq_mask_q, 1'b0, 2'd`POS_OV); // (R07)
   assign rail_four_current_irq_block =
      get_bit(rail_pair_b_fault_irq_mask_q, 1'b1, 2'd`POS_ILIM); // (R07)
   assign rail_four_undervolt_irq_block =
      get_bit(rail_pair_b_fault_irq_mask_q, 1'b1, 2'd`POS_UV); // (R07)
   assign rail_four_overvolt_irq_block =
      get_bit(rail_pair_b_fault_irq_mask_q, 1'b1, 2'd`POS_OV); // (R07)

   // Pin fields; bits 7:4 are storage only and steer nothing
   assign pin_mask_w = upper_pin_trigger_mask_q;
   assign pin_nine_trigger_block = pin_mask_w[`POS_P9_BLOCK]; // (R01)
   assign pin_nine_trigger_forced_level = pin_mask_w[`POS_P9_LEVEL]; // (R02)
   assign pin_ten_trigger_block = pin_mask_w[`POS_P10_BLOCK]; // (R01)
   assign pin_ten_trigger_forced_level = pin_mask_w[`POS_P10_LEVEL]; // (R02)

   // ---------------------------------------------------------
   // Interrupt gating
   // ---------------------------------------------------------
   // Event passes only while its mask bit is clear; the gate is
   // combinational, so an event is neither delayed nor stretched.
   // Bit 0 is rail one, bit 3 rail four.
   assign rail_current_irq = rail_current_event &
      ~{rail_four_current_irq_block, rail_three_current_irq_block,
      rail_two_current_irq_block, rail_one_current_irq_block}; // (R04)
   assign rail_undervolt_irq = rail_undervolt_event &
      ~{rail_four_undervolt_irq_block, rail_three_undervolt_irq_block,
      rail_two_undervolt_irq_block, rail_one_undervolt_irq_block}; // (R05)
   assign rail_overvolt_irq = rail_overvolt_event &
      ~{rail_four_overvolt_irq_block, rail_three_overvolt_irq_block,
      rail_two_overvolt_irq_block, rail_one_overvolt_irq_block}; // (R06)

   // ---------------------------------------------------------
   // Pin triggers
   // ---------------------------------------------------------
   // A masked trigger shows a fixed level, so the state machine
   // never sees a stale pin value frozen at the moment of masking
   pin_trigger_gate u_pin_nine (
      .trigger_in(pin_nine_trigger_in),
      .block(pin_nine_trigger_block),
      .forced_level(pin_nine_trigger_forced_level),
      .trigger_out(pin_nine_trigger_out)
   );
   pin_trigger_gate u_pin_ten (
      .trigger_in(pin_ten_trigger_in),
      .block(pin_ten_trigger_block),
      .forced_level(pin_ten_trigger_forced_level),
      .trigger_out(pin_ten_trigger_out)
   );
endmodule // regulator_fault_irq_mask_bank

// ---- regulator_fault_irq_mask_bank_bench.sv ----
`timescale 1ns/1ps
module regulator_fault_irq_mask_bank_bench;
   logic clk, rst_n, reg_wr, nvm_load, pin_nine_trigger_in, pin_ten_trigger_in;
   logic [7:0] reg_addr, reg_wdata, nvm_rail_pair_a, nvm_rail_pair_b;
   logic [7:0] nvm_upper_pin;
   logic [3:0] rail_current_event, rail_undervolt_event, rail_overvolt_event;
   wire [7:0] reg_rdata;
   wire reg_hit, pin_nine_trigger_out, pin_ten_trigger_out;
   wire [3:0] rail_current_irq, rail_undervolt_irq, rail_overvolt_irq;
   int failures, checks_done;
   regulator_fault_irq_mask_bank uut (.*);
   task automatic chk(input [7:0] got, input [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input [7:0] a, input [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Reads are combinational, so sample at the falling edge
   task automatic rd(input [7:0] a, input [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      @(negedge clk);
      chk(reg_rdata, exp);
      chk({7'h00, reg_hit}, {7'h00, a inside {8'h48, 8'h49, 8'h4a}});
   endtask
   // Walk one bit through each pair, different bits in A and B
   task t_rails;
      logic [7:0] a, b;
      for (int i = 0; i < 8; i++) begin
         a = 8'h01 << i;
         b = 8'h80 >> i;
         wr(8'h49, a);
         wr(8'h4a, b);
         rd(8'h49, a);
         rd(8'h4a, b);
         chk({4'h0, rail_current_irq},
            {4'h0, ~{b[7], b[3], a[7], a[3]}});
         chk({4'h0, rail_undervolt_irq},
            {4'h0, ~{b[5], b[1], a[5], a[1]}});
         chk({4'h0, rail_overvolt_irq},
            {4'h0, ~{b[4], b[0], a[4], a[0]}});
      end
      // Masks clear: each irq must follow its own event
      wr(8'h49, 8'h00);
      wr(8'h4a, 8'h00);
      {rail_current_event, rail_undervolt_event} <= 8'h5a;
      rail_overvolt_event <= 4'h3;
      @(negedge clk);
      chk({4'h0, rail_current_irq}, 8'h05);
      chk({4'h0, rail_undervolt_irq}, 8'h0a);
      chk({4'h0, rail_overvolt_irq}, 8'h03);
   endtask
   // All block and level settings against both trigger levels
   task t_pins;
      for (int i = 0; i < 64; i++) begin
         wr(8'h48, {4'h5, i[3:0]});
         pin_nine_trigger_in <= i[4];
         pin_ten_trigger_in <= i[5];
         @(negedge clk);
         chk({6'h00, pin_ten_trigger_out, pin_nine_trigger_out},
            {6'h00, (i[2] ? i[3] : i[5]), (i[0] ? i[1] : i[4])});
      end
   endtask
   // Load beats a same-cycle write; unmapped writes vanish
   task t_nvm;
      @(posedge clk);
      {nvm_rail_pair_a, nvm_rail_pair_b, nvm_upper_pin} <= 24'h3cc3a6;
      {nvm_load, reg_wr, reg_addr, reg_wdata} <= {2'b11, 16'h48ff};
      @(posedge clk);
      {nvm_load, reg_wr} <= 2'b00;
      rd(8'h48, 8'ha6);
      rd(8'h4a, 8'hc3);
      wr(8'h4b, 8'hff);
      rd(8'h4b, 8'h00);
      rd(8'h49, 8'h3c);
   endtask
   initial begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      {rst_n, reg_wr, nvm_load, pin_nine_trigger_in, pin_ten_trigger_in} = 0;
      {reg_addr, reg_wdata, nvm_rail_pair_a, nvm_rail_pair_b} = 0;
      nvm_upper_pin = 0;
      {rail_current_event, rail_undervolt_event, rail_overvolt_event} = 12'hfff;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h48, 8'h00);
      rd(8'h4a, 8'h00);
      t_rails;
      t_pins;
      rd(8'h48, 8'h5f);
      t_nvm;
      finish_test;
   end
   // Whole run needs well under 600 cycles
   initial begin
      repeat (2000) @(posedge clk);
      failures++;
      finish_test;
   end
   task finish_test;
      if (failures == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
endmodule // regulator_fault_irq_mask_bank_bench
